// File: src/result_ring_regs.svh
`ifndef RESULT_RING_REGS_SVH
`define RESULT_RING_REGS_SVH
// ****************************************************************
// low word bit positions
// ****************************************************************
`define RR_VALID_BIT 31
`define RR_OVERFLOW_BIT 30
`define RR_CMD_ERR_BIT 29
`define RR_HOST_ABORT_BIT 28
`define RR_TIMEOUT_BIT 27
`define RR_CIPHER_BIT 26
`define RR_ORDER_BIT 25
`define RR_CORRUPT_BIT 24
`define RR_PARITY_BIT 23
`define RR_SUMMARY_BIT 22
`define RR_CMP_TOKEN_BIT 21
`define RR_CMP_CRC_BIT 20
`define RR_CMP_OVERRUN_BIT 19
`define RR_CMP_DATA_BIT 18
`define RR_CMP_RCRC_BIT 17
`define RR_IDX_HI_MSB 16
`define RR_IDX_HI_LSB 11
`define RR_MGR_MSB 10
`define RR_MGR_LSB 8
`define RR_IDX_LO_MSB 7
`define RR_IDX_LO_LSB 0
`define RR_IDX_SPLIT 8
// ****************************************************************
// high word bit positions (64-bit entry)
// ****************************************************************
`define RR_M_TIMEOUT_BIT 61
`define RR_M_ABORT_BIT 60
`define RR_M_CORRUPT_BIT 59
`define RR_M_CRC_BIT 58
`define RR_M_KEY_SLOT_BIT 57
`define RR_M_WIDE_KEY_BIT 56
`define RR_M_KEY_ACC_BIT 55
`define RR_M_PARITY_BIT 54
`define RR_C_CRC_BIT 48
`define RR_C_VERIFY_BIT 47
`define RR_C_AUTH_BIT 46
`define RR_D_CRC_BIT 44
`define RR_D_VERIFY_BIT 43
`define RR_Z_TOKEN_BIT 40
`define RR_Z_CRC_BIT 39
`define RR_Z_OVERRUN_BIT 38
`define RR_Z_DATA_BIT 37
`define RR_Z_RCRC_BIT 36
// ****************************************************************
// entry sizes and reset values
// ****************************************************************
`define RR_NARROW_BYTES_LOG2 2
`define RR_WIDE_BYTES_LOG2 3
`define RR_MGR_MAX 3'h5
`define RR_PHASE_RESET 1'h1
`endif

// File: src/result_ring_pkg.sv
`default_nettype none
package result_ring_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_post
  } post_state_t;
  typedef logic [63:0] entry_t;
endpackage : result_ring_pkg
`default_nettype wire

// File: src/result_ring_pointer.sv
`include "result_ring_regs.svh"
`default_nettype none
module result_ring_pointer #(
  parameter int IDX_W = 14
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_advance,
  input wire logic [IDX_W:0] i_ring_entries,
  output logic [IDX_W-1:0] o_ptr,
  output logic o_phase
);
  logic [IDX_W-1:0] ptr_q;
  logic [IDX_W-1:0] ptr_d;
  logic phase_q;
  logic phase_d;

  // ****************************************************************
  // write pointer, wraps at command pointer ring size
  // ****************************************************************
  always_comb begin
    ptr_d = ptr_q;
    phase_d = phase_q;
    if (i_advance) begin
      if ({1'b0, ptr_q} + {{IDX_W{1'b0}}, 1'b1} >= i_ring_entries) begin
        ptr_d = '0;
        phase_d = ~phase_q;
      end else begin
        ptr_d = ptr_q + {{(IDX_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_q <= '0;
      phase_q <= `RR_PHASE_RESET;
    end else begin
      ptr_q <= ptr_d;
      phase_q <= phase_d;
    end
  end

  assign o_ptr = ptr_q;
  assign o_phase = phase_q;
endmodule : result_ring_pointer
`default_nettype wire

// File: src/result_ring_status_writer.sv
// Function
// - write one entry per finished command, then advance the write pointer.
// - ring holds as many entries as the command pointer ring; wrap there.
// - entry format selectable, 32-bit or 64-bit.
// - bit 31 valid marker inverts each time the pointer wraps.
// - bit 30 set on destination buffer overflow.
// - bit 29 is OR of all error flags except overflow.
// - aborted host read terminates command and sets bit 28.
// - bit 27 set on read completion timeout.
// - bit 26 set on encryption engine error.
// - bit 25 set on out-of-order completion packets.
// - bit 24 set on missing end-of-record or output after it.
// - bit 23 set on transfer ECC or parity error.
// - bit 22 summary set when any error flag is set.
// - compressor faults on bits 21 to 17.
// - 14-bit command index split into 16:11 and 7:0.
// - bits 10:8 carry reporting manager 0 to 5.
// - 64-bit entry: summary in 31:17, detail in 63:32.
// - manager timeout 61, host abort 60, corruption 59.
// - manager crc 58, key slot 57, wide key 56, key access 55, parity 54.
// - cipher crc 48, verify 47, auth 46, digest crc 44, verify 43.
// - compressor detail on bits 40 to 36.
`include "result_ring_regs.svh"
`default_nettype none
module result_ring_status_writer
  import result_ring_pkg::*;
#(
  parameter int IDX_W = 14,
  parameter int ADDR_W = 64
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wide_format,
  input wire logic [ADDR_W-1:0] i_ring_base,
  input wire logic [IDX_W:0] i_ring_entries,
  input wire logic i_cmpl_valid,
  output logic o_cmpl_ready,
  input wire logic [IDX_W-1:0] i_completed_command_index,
  input wire logic [2:0] i_reporting_manager_id,
  input wire logic i_dest_overflow_flag,
  input wire logic i_host_abort_flag,
  input wire logic i_read_reply_timeout_flag,
  input wire logic i_cipher_engine_fault,
  input wire logic i_reply_order_fault,
  input wire logic i_record_end_marker,
  input wire logic i_output_after_end,
  input wire logic i_dma_parity_fault,
  input wire logic i_compressor_token_fault,
  input wire logic i_compressor_checksum_fault,
  input wire logic i_compressor_overrun_fault,
  input wire logic i_compressor_data_fault,
  input wire logic i_record_checksum_fault,
  input wire logic i_manager_checksum_fault,
  input wire logic i_manager_key_slot_fault,
  input wire logic i_manager_wide_key_fault,
  input wire logic i_manager_key_access_fault,
  input wire logic i_manager_parity_fault,
  input wire logic i_cipher_checksum_fault,
  input wire logic i_cipher_verify_fault,
  input wire logic i_cipher_auth_fault,
  input wire logic i_digest_checksum_fault,
  input wire logic i_digest_verify_fault,
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output logic [ADDR_W-1:0] o_wr_addr,
  output result_ring_pkg::entry_t o_wr_data,
  output logic o_wr_wide,
  output logic o_cmd_terminate,
  output logic [IDX_W-1:0] o_wr_ptr,
  output logic o_valid_phase
);
  import result_ring_pkg::*;

  if (IDX_W < 9 || IDX_W > 14 || ADDR_W < IDX_W + 4) begin : g_param_check
    $error("result_ring_status_writer: unsupported IDX_W or ADDR_W");
  end

  post_state_t state_q;
  post_state_t state_d;
  logic ready_q;
  logic ready_d;
  logic wr_valid_q;
  logic wr_valid_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  entry_t data_q;
  entry_t data_d;
  logic wide_q;
  logic wide_d;
  logic term_q;
  logic term_d;
  logic advance;
  logic take;
  logic [IDX_W-1:0] ptr;
  logic phase;
  logic [13:0] idx14;
  logic corrupt;
  logic cipher_any;
  logic cmd_err;
  logic any_err;
  entry_t entry;
  logic [ADDR_W-1:0] offset;

  // ****************************************************************
  // pointer and wrap phase
  // ****************************************************************
  result_ring_pointer #(
    .IDX_W(IDX_W)
  ) u_pointer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_advance(advance),
    .i_ring_entries(i_ring_entries),
    .o_ptr(ptr),
    .o_phase(phase)
  );

  // ****************************************************************
  // entry assembly
  // ****************************************************************
  always_comb begin
    idx14 = 14'(i_completed_command_index);
    corrupt = ~i_record_end_marker | i_output_after_end;
    cipher_any = i_cipher_engine_fault | i_cipher_checksum_fault | i_cipher_verify_fault | i_cipher_auth_fault;
    cmd_err = i_host_abort_flag | i_read_reply_timeout_flag | cipher_any | i_reply_order_fault | corrupt
            | i_dma_parity_fault | i_compressor_token_fault | i_compressor_checksum_fault
            | i_compressor_overrun_fault | i_compressor_data_fault | i_record_checksum_fault
            | i_manager_checksum_fault | i_manager_key_slot_fault | i_manager_wide_key_fault
            | i_manager_key_access_fault | i_manager_parity_fault | i_digest_checksum_fault
            | i_digest_verify_fault;
    any_err = cmd_err | i_dest_overflow_flag;
    entry = '0;
    entry[`RR_VALID_BIT] = phase;
    entry[`RR_OVERFLOW_BIT] = i_dest_overflow_flag;
    entry[`RR_CMD_ERR_BIT] = cmd_err;
    entry[`RR_HOST_ABORT_BIT] = i_host_abort_flag;
    entry[`RR_TIMEOUT_BIT] = i_read_reply_timeout_flag;
    entry[`RR_CIPHER_BIT] = cipher_any;
    entry[`RR_ORDER_BIT] = i_reply_order_fault;
    entry[`RR_CORRUPT_BIT] = corrupt;
    entry[`RR_PARITY_BIT] = i_dma_parity_fault;
    entry[`RR_SUMMARY_BIT] = any_err;
    entry[`RR_CMP_TOKEN_BIT] = i_compressor_token_fault;
    entry[`RR_CMP_CRC_BIT] = i_compressor_checksum_fault;
    entry[`RR_CMP_OVERRUN_BIT] = i_compressor_overrun_fault;
    entry[`RR_CMP_DATA_BIT] = i_compressor_data_fault;
    entry[`RR_CMP_RCRC_BIT] = i_record_checksum_fault;
    entry[`RR_IDX_HI_MSB:`RR_IDX_HI_LSB] = idx14[13:`RR_IDX_SPLIT];
    entry[`RR_IDX_LO_MSB:`RR_IDX_LO_LSB] = idx14[`RR_IDX_SPLIT-1:0];
    if (i_reporting_manager_id <= `RR_MGR_MAX) begin
      entry[`RR_MGR_MSB:`RR_MGR_LSB] = i_reporting_manager_id;
    end
    if (i_wide_format) begin
      entry[`RR_M_TIMEOUT_BIT] = i_read_reply_timeout_flag;
      entry[`RR_M_ABORT_BIT] = i_host_abort_flag;
      entry[`RR_M_CORRUPT_BIT] = corrupt;
      entry[`RR_M_CRC_BIT] = i_manager_checksum_fault;
      entry[`RR_M_KEY_SLOT_BIT] = i_manager_key_slot_fault;
      entry[`RR_M_WIDE_KEY_BIT] = i_manager_wide_key_fault;
      entry[`RR_M_KEY_ACC_BIT] = i_manager_key_access_fault;
      entry[`RR_M_PARITY_BIT] = i_manager_parity_fault;
      entry[`RR_C_CRC_BIT] = i_cipher_checksum_fault;
      entry[`RR_C_VERIFY_BIT] = i_cipher_verify_fault;
      entry[`RR_C_AUTH_BIT] = i_cipher_auth_fault;
      entry[`RR_D_CRC_BIT] = i_digest_checksum_fault;
      entry[`RR_D_VERIFY_BIT] = i_digest_verify_fault;
      entry[`RR_Z_TOKEN_BIT] = i_compressor_token_fault;
      entry[`RR_Z_CRC_BIT] = i_compressor_checksum_fault;
      entry[`RR_Z_OVERRUN_BIT] = i_compressor_overrun_fault;
      entry[`RR_Z_DATA_BIT] = i_compressor_data_fault;
      entry[`RR_Z_RCRC_BIT] = i_record_checksum_fault;
    end
    if (i_wide_format) begin
      offset = ADDR_W'({ptr, {`RR_WIDE_BYTES_LOG2{1'b0}}});
    end else begin
      offset = ADDR_W'({ptr, {`RR_NARROW_BYTES_LOG2{1'b0}}});
    end
  end

  // ****************************************************************
  // posting sequence
  // ****************************************************************
  assign take = ready_q & i_cmpl_valid;
  assign advance = (state_q == st_post) & i_wr_ready;

  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    data_d = data_q;
    wide_d = wide_q;
    wr_valid_d = wr_valid_q;
    term_d = 1'b0;
    unique case (state_q)
      st_idle: begin
        if (take) begin
          state_d = st_post;
          addr_d = i_ring_base + offset;
          data_d = entry;
          wide_d = i_wide_format;
          wr_valid_d = 1'b1;
          term_d = i_host_abort_flag;
        end
      end
      st_post: begin
        if (i_wr_ready) begin
          state_d = st_idle;
          wr_valid_d = 1'b0;
        end
      end
      default: begin
        state_d = st_idle;
        wr_valid_d = 1'b0;
      end
    endcase
    ready_d = (state_d == st_idle);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= st_idle;
      ready_q <= 1'b0;
      wr_valid_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      wide_q <= 1'b0;
      term_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      wr_valid_q <= wr_valid_d;
      addr_q <= addr_d;
      data_q <= data_d;
      wide_q <= wide_d;
      term_q <= term_d;
    end
  end

  assign o_cmpl_ready = ready_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr_addr = addr_q;
  assign o_wr_data = data_q;
  assign o_wr_wide = wide_q;
  assign o_cmd_terminate = term_q;
  assign o_wr_ptr = ptr;
  assign o_valid_phase = phase;
endmodule : result_ring_status_writer
`default_nettype wire

// File: tb/result_ring_chk.sv
`default_nettype none
// ****************************************************************
// port checks of the result ring writer
// ****************************************************************
module result_ring_chk #(
  parameter int IDX_W = 14,
  parameter int ADDR_W = 64
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cmpl_valid,
  input wire logic o_cmpl_ready,
  input wire logic i_host_abort_flag,
  input wire logic [ADDR_W-1:0] i_ring_base,
  input wire logic o_wr_valid,
  input wire logic i_wr_ready,
  input wire logic [ADDR_W-1:0] o_wr_addr,
  input wire result_ring_pkg::entry_t o_wr_data,
  input wire logic o_wr_wide,
  input wire logic o_cmd_terminate,
  input wire logic [IDX_W-1:0] o_wr_ptr,
  input wire logic o_valid_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  import result_ring_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_take_then_write: assert property (i_cmpl_valid && o_cmpl_ready |=> o_wr_valid && !o_cmpl_ready)
    else $error("no write after take");
  a_write_held: assert property (o_wr_valid && !i_wr_ready |=>
    o_wr_valid && $stable(o_wr_data) && $stable(o_wr_addr)) else $error("write dropped");
  a_ptr_advance: assert property (o_wr_valid && i_wr_ready |=> !o_wr_valid && o_cmpl_ready &&
    ((o_wr_ptr == $past(o_wr_ptr) + 1'b1 && o_valid_phase == $past(o_valid_phase))
    || (o_wr_ptr == '0 && o_valid_phase != $past(o_valid_phase)))) else $error("pointer step wrong");
  a_valid_marker: assert property (o_wr_valid |-> o_wr_data[31] == o_valid_phase)
    else $error("valid bit wrong");
  a_narrow_zero: assert property (o_wr_valid && !o_wr_wide |-> o_wr_data[63:32] == 32'h0)
    else $error("upper word set");
  a_entry_addr: assert property (o_wr_valid |->
    o_wr_addr == i_ring_base + (ADDR_W'(o_wr_ptr) << (o_wr_wide ? 3 : 2))) else $error("address wrong");
  a_summary_bit: assert property (o_wr_valid |->
    o_wr_data[22] == (o_wr_data[30] || o_wr_data[29])) else $error("summary bit wrong");
  a_cmd_err: assert property (o_wr_valid && (|o_wr_data[28:23] || |o_wr_data[21:17]) |-> o_wr_data[29])
    else $error("command error bit clear");
  a_abort_pulse: assert property (i_cmpl_valid && o_cmpl_ready |=>
    o_cmd_terminate == $past(i_host_abort_flag) ##1 !o_cmd_terminate) else $error("terminate wrong");
endmodule : result_ring_chk
bind result_ring_status_writer result_ring_chk #(.IDX_W(IDX_W), .ADDR_W(ADDR_W)) i_chk (.i_clk, .i_rst,
  .i_cmpl_valid, .o_cmpl_ready, .i_host_abort_flag, .i_ring_base, .o_wr_valid, .i_wr_ready, .o_wr_addr,
  .o_wr_data, .o_wr_wide, .o_cmd_terminate, .o_wr_ptr, .o_valid_phase);
`default_nettype wire

// File: tb/host_ring_model.sv
`default_nettype none
// ****************************************************************
// host memory taking posted entry writes
// ****************************************************************
module host_ring_model (
  input wire logic i_clk,
  input wire logic i_stall,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [63:0] o_ring_base,
  output int o_writes
);
  timeunit 1ns;
  timeprecision 1ps;
  assign o_ring_base = 64'h0000_1000_0000_0a48;
  initial o_wr_ready = 1'b0;
  initial o_writes = 0;
  always @(posedge i_clk) begin
    if (i_wr_valid && o_wr_ready) o_writes <= o_writes + 1;
    o_wr_ready <= !i_stall;
  end
endmodule : host_ring_model
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
// ****************************************************************
// completion stimulus and entry model
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import result_ring_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, vld = 1'b0, wide = 1'b0, stall = 1'b0, m_ph;
  logic rdy, wr_v, wr_w, cmpl_rdy, term, phase;
  logic [13:0] idx = 14'h0, ptr;
  logic [2:0] mgr = 3'h0;
  logic [22:0] f = 23'h0;
  logic [14:0] ents = 15'h5;
  logic [63:0] base, wr_a;
  entry_t wr_d;
  logic [31:0] seed = 32'h89e6;
  int writes, err_count = 0, n_compared = 0, cyc = 0, m_ptr, k;
  result_ring_status_writer i_dut (.i_clk, .i_rst, .i_wide_format(wide), .i_ring_base(base),
    .i_ring_entries(ents), .i_cmpl_valid(vld), .o_cmpl_ready(cmpl_rdy), .i_completed_command_index(idx),
    .i_reporting_manager_id(mgr), .i_dest_overflow_flag(f[0]), .i_host_abort_flag(f[1]),
    .i_read_reply_timeout_flag(f[2]), .i_cipher_engine_fault(f[3]), .i_reply_order_fault(f[4]),
    .i_record_end_marker(~f[5]), .i_output_after_end(f[6]), .i_dma_parity_fault(f[7]),
    .i_compressor_token_fault(f[8]), .i_compressor_checksum_fault(f[9]), .i_compressor_overrun_fault(f[10]),
    .i_compressor_data_fault(f[11]), .i_record_checksum_fault(f[12]), .i_manager_checksum_fault(f[13]),
    .i_manager_key_slot_fault(f[14]), .i_manager_wide_key_fault(f[15]), .i_manager_key_access_fault(f[16]),
    .i_manager_parity_fault(f[17]), .i_cipher_checksum_fault(f[18]), .i_cipher_verify_fault(f[19]),
    .i_cipher_auth_fault(f[20]), .i_digest_checksum_fault(f[21]), .i_digest_verify_fault(f[22]),
    .o_wr_valid(wr_v), .i_wr_ready(rdy), .o_wr_addr(wr_a), .o_wr_data(wr_d), .o_wr_wide(wr_w),
    .o_cmd_terminate(term), .o_wr_ptr(ptr), .o_valid_phase(phase));
  host_ring_model i_host (.i_clk, .i_stall(stall), .i_wr_valid(wr_v), .o_wr_ready(rdy), .o_ring_base(base),
    .o_writes(writes));
  always #10 i_clk = ~i_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic entry_t exp_entry(logic [22:0] e, logic [13:0] x, logic [2:0] m, logic w, logic ph);
    entry_t r;
    r = '0;
    r[31:17] = {ph, e[0], |e[22:1], e[1], e[2], e[3] | (|e[20:18]), e[4], e[5] | e[6], e[7], |e,
      e[8], e[9], e[10], e[11], e[12]};
    r[16:0] = {x[13:8], ((m > 3'h5) ? 3'h0 : m), x[7:0]};
    if (w) r[61:36] = {e[2], e[1], e[5] | e[6], e[13], e[14], e[15], e[16], e[17], 5'h0, e[18], e[19],
      e[20], 1'h0, e[21], e[22], 2'h0, e[8], e[9], e[10], e[11], e[12]};
    return r;
  endfunction : exp_entry
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic run_cmd(logic [22:0] e, logic [13:0] x, logic [2:0] m, logic w);
    entry_t d;
    f <= e;
    idx <= x;
    mgr <= m;
    wide <= w;
    vld <= 1'b1;
    do @(posedge i_clk); while (cmpl_rdy !== 1'b1);
    vld <= 1'b0;
    d = exp_entry(e, x, m, w, m_ph);
    @(posedge i_clk);
    chk("terminate", 64'(e[1]), 64'(term));
    while (!(wr_v === 1'b1 && rdy === 1'b1)) @(posedge i_clk);
    chk("entry", d, wr_d);
    chk("address", base + 64'(m_ptr * (w ? 8 : 4)), wr_a);
    chk("width", 64'(w), 64'(wr_w));
    m_ptr = (m_ptr + 1 >= ents) ? 0 : m_ptr + 1;
    if (m_ptr == 0) m_ph = ~m_ph;
  endtask : run_cmd
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    stall <= (cyc % 5) > 2;
    if (cyc == 4000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    m_ptr = 0;
    m_ph = 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk("phase after reset", 64'h1, 64'(phase));
    for (k = 0; k < 46; k++) run_cmd(23'h1 << (k % 23), (k == 0) ? 14'h3fff : 14'(rnd()), 3'(k), k >= 23);
    for (k = 0; k < 30; k++) run_cmd(23'(rnd() & rnd() & rnd()), 14'(rnd()), 3'(rnd()), 1'(rnd()));
    i_rst <= 1'b1;
    ents <= 15'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    m_ptr = 0;
    m_ph = 1'b1;
    @(posedge i_clk);
    chk("pointer after reset", 64'h0, 64'(ptr));
    chk("phase after reset", 64'h1, 64'(phase));
    for (k = 0; k < 5; k++) run_cmd(23'(rnd()), 14'(rnd()), 3'(rnd()), 1'(rnd()));
    @(posedge i_clk);
    chk("write count", 64'h51, 64'(writes));
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
